/* sdlfs_err_cnt.sv */
// Saturating error counter with x128 scaled reporting
`timescale 1ns/1ps
module sdlfs_err_cnt #(
	parameter int COUNT_W = 15,
	parameter int SCALE_SHIFT = 7
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Control
	input wire logic err_hit,
	input wire logic clr,
	// Report
	output logic [COUNT_W-1:0] count,
	output logic scale
);

	localparam int RAW_W = COUNT_W + SCALE_SHIFT;

	typedef struct packed {
		logic [RAW_W-1:0] raw;
	} sdlfs_cnt_s;

	sdlfs_cnt_s st_r;
	sdlfs_cnt_s st_nxt;

	if (COUNT_W < 2 || SCALE_SHIFT < 1) $error("sdlfs_err_cnt widths too small");

	always_comb
	begin
		st_nxt = st_r;
		if (clr)
			st_nxt.raw = {{(RAW_W-1){1'b0}}, err_hit};
		else if (err_hit && !(&st_r.raw))
			st_nxt.raw = st_r.raw + {{(RAW_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Above the plain range the count is reported in units of 128
	assign scale = |st_r.raw[RAW_W-1:COUNT_W];
	assign count = scale ? st_r.raw[RAW_W-1:SCALE_SHIFT] : st_r.raw[COUNT_W-1:0];

endmodule : sdlfs_err_cnt

/* sdlfs_pkg.sv */
// Shared constants for the transceiver level, frequency and error-count register bank
package sdlfs_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] BASE_ADR = 12'h800;
	localparam logic [11:0] OFF_EC = 12'h030;
	localparam logic [11:0] OFF_FI = 12'h034;
	localparam logic [11:0] OFF_STAT = 12'h420;
	localparam logic [11:0] OFF_LEVEL_OVERRIDE_ENABLE = 12'h428;
	localparam logic [11:0] OFF_IRQ_ST = 12'h440;
	localparam logic [11:0] OFF_IRQ_MSK = 12'h444;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int LVL_W = 5;
	localparam int TX_LSB = 26;
	localparam int LOS_LSB = 21;
	localparam int CMP_LSB = 16;
	localparam int LEVEL_OVERRIDE_ENABLE_BIT = 31;
	localparam int COUNT_W = 15;
	localparam int SCALE_BIT = 15;
	localparam int DITHER_BIT = 16;
	localparam int SCALE_SHIFT = 7;
	localparam int FREQ_W = 14;
	localparam int KEEP_W = 16;
	localparam int IRQ_W = 2;
	localparam int IRQ_ERR = 0;
	localparam int IRQ_OVF = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [4:0] STAT_TX_RST = 5'h10;
	localparam logic [4:0] STAT_LOS_RST = 5'h12;
	localparam logic [4:0] STAT_CMP_RST = 5'h00;
	localparam logic [4:0] LEVEL_OVERRIDE_ENABLE_LVL_RST = 5'h10;
	localparam logic STAT_RSVD_HI = 1'h1;
	localparam logic [15:0] STAT_RSVD_LO = 16'hFFFF;

endpackage : sdlfs_pkg

/* sdlfs_regs.sv */
// Wishbone register bank: error counter, frequency readout, level status and override
//
// Behaviour
// - Each register sits at the transceiver base 0x800 plus its own offset.
// - The error counter register shows the error count in bits 14:0.
// - With the scale flag at 1 the count is in units of 128 errors, at 0 it is unscaled.
// - Scale flag 1 together with an all-ones count signals counter overflow.
// - Error counter reads are pipelined, so a read returns the value caught by the read before it.
// - Every second read of the error counter clears it; the count may move between reads.
// - The frequency field reports a signed offset in 1.526 ppm units in bits 13:1.
// - Frequency value and its dither bit may need a repeated read to settle.
// - Level status follows the transceiver inputs and is not in force while override is on.
// - Level status holds read-only transmit, signal-loss and comparator levels with their reset values.
// - Override enable in bit 31 makes the override levels replace the status levels; it resets to 0.
// - The override register holds writable levels at 30:26, 25:21, 20:16, each resetting to 0x10.
`timescale 1ns/1ps
module sdlfs_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Transceiver inputs
	input wire logic err_hit,
	input wire logic phase_dither_bit,
	input wire logic [12:0] freq_offset_value,
	input wire logic freq_dither_bit,
	input wire logic [4:0] tx_level_in,
	input wire logic [4:0] signal_loss_level_in,
	input wire logic [4:0] scan_comparator_level_in,
	// Applied levels
	output logic [4:0] tx_level_out,
	output logic [4:0] signal_loss_level_out,
	output logic [4:0] scan_comparator_level_out,
	// Interrupt
	output logic irq_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam int SYNC_W = 1 + sdlfs_pkg::FREQ_W + 3 * sdlfs_pkg::LVL_W;
	localparam logic [SYNC_W-1:0] SYNC_RST = {1'b0, 14'h0000, sdlfs_pkg::STAT_TX_RST,
		sdlfs_pkg::STAT_LOS_RST, sdlfs_pkg::STAT_CMP_RST};

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [16:0] snap;
		logic rd_odd;
		logic level_override_enable;
		logic [4:0] level_override_enable_tx;
		logic [4:0] level_override_enable_los;
		logic [4:0] level_override_enable_cmp;
		logic [15:0] preserve_on_write_bits;
		logic [1:0] irq_st;
		logic [1:0] irq_msk;
		logic ovf_prev;
		logic [4:0] tx_o;
		logic [4:0] los_o;
		logic [4:0] cmp_o;
	} sdlfs_regs_s;

	localparam sdlfs_regs_s ST_RST = '{
		level_override_enable_tx: sdlfs_pkg::LEVEL_OVERRIDE_ENABLE_LVL_RST,
		level_override_enable_los: sdlfs_pkg::LEVEL_OVERRIDE_ENABLE_LVL_RST,
		level_override_enable_cmp: sdlfs_pkg::LEVEL_OVERRIDE_ENABLE_LVL_RST,
		tx_o: sdlfs_pkg::STAT_TX_RST,
		los_o: sdlfs_pkg::STAT_LOS_RST,
		cmp_o: sdlfs_pkg::STAT_CMP_RST,
		default: '0
	};

	sdlfs_regs_s st_r;
	sdlfs_regs_s st_nxt;

	logic [SYNC_W-1:0] sync_q;
	logic sy_pdither;
	logic [13:0] sy_freq;
	logic [4:0] sy_tx;
	logic [4:0] sy_los;
	logic [4:0] sy_cmp;
	logic [14:0] cnt_val;
	logic cnt_scale;
	logic cnt_ovf;
	logic cnt_clr;
	logic req;
	logic [31:0] rdata;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [1:0] evt;

	// ----------------------------------------
	// Input synchroniser and error counter
	// ----------------------------------------
	sdlfs_sync #(
		.W(SYNC_W),
		.RST(SYNC_RST)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.d({phase_dither_bit, freq_offset_value, freq_dither_bit, tx_level_in,
			signal_loss_level_in, scan_comparator_level_in}),
		.q(sync_q)
	);

	assign {sy_pdither, sy_freq, sy_tx, sy_los, sy_cmp} = sync_q;

	sdlfs_err_cnt #(
		.COUNT_W(sdlfs_pkg::COUNT_W),
		.SCALE_SHIFT(sdlfs_pkg::SCALE_SHIFT)
	) u_cnt (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.err_hit(err_hit),
		.clr(cnt_clr),
		.count(cnt_val),
		.scale(cnt_scale)
	);

	assign cnt_ovf = cnt_scale & (&cnt_val);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		req = wb_cyc_i & wb_stb_i & ~st_r.ack;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		wval = wb_dat_i & wmask;
		rdata = 32'h0000_0000;
		cnt_clr = 1'b0;
		evt = {cnt_ovf & ~st_r.ovf_prev, err_hit};
		st_nxt.ack = req;
		st_nxt.ovf_prev = cnt_ovf;
		// Applied levels come from override when enabled
		st_nxt.tx_o = st_r.level_override_enable ? st_r.level_override_enable_tx : sy_tx;
		st_nxt.los_o = st_r.level_override_enable ? st_r.level_override_enable_los : sy_los;
		st_nxt.cmp_o = st_r.level_override_enable ? st_r.level_override_enable_cmp : sy_cmp;
		st_nxt.irq_st = st_r.irq_st | evt;
		if (req && wb_adr_i == 12'(sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_EC))
		begin
			rdata = {15'h0000, st_r.snap};
			if (!wb_we_i)
			begin
				st_nxt.snap = {sy_pdither, cnt_scale, cnt_val};
				st_nxt.rd_odd = ~st_r.rd_odd;
				cnt_clr = st_r.rd_odd;
			end
		end
		else if (req && wb_adr_i == 12'(sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_FI))
			rdata = {18'h00000, sy_freq};
		else if (req && wb_adr_i == 12'(sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_STAT))
			rdata = {sdlfs_pkg::STAT_RSVD_HI, sy_tx, sy_los, sy_cmp, sdlfs_pkg::STAT_RSVD_LO};
		else if (req && wb_adr_i == 12'(sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_LEVEL_OVERRIDE_ENABLE))
		begin
			rdata = {st_r.level_override_enable, st_r.level_override_enable_tx, st_r.level_override_enable_los, st_r.level_override_enable_cmp,
				st_r.preserve_on_write_bits};
			if (wb_we_i)
			begin
				if (wb_sel_i[3])
					st_nxt.level_override_enable = wb_dat_i[sdlfs_pkg::LEVEL_OVERRIDE_ENABLE_BIT];
				if (wb_sel_i[3])
					st_nxt.level_override_enable_tx = wb_dat_i[sdlfs_pkg::TX_LSB +: sdlfs_pkg::LVL_W];
				if (wb_sel_i[3] && wb_sel_i[2])
					st_nxt.level_override_enable_los = wb_dat_i[sdlfs_pkg::LOS_LSB +: sdlfs_pkg::LVL_W];
				if (wb_sel_i[2])
					st_nxt.level_override_enable_cmp = wb_dat_i[sdlfs_pkg::CMP_LSB +: sdlfs_pkg::LVL_W];
				st_nxt.preserve_on_write_bits = (st_r.preserve_on_write_bits & ~wmask[15:0])
					| wval[15:0];
			end
		end
		else if (req && wb_adr_i == 12'(sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_IRQ_ST))
		begin
			rdata = {30'h0000_0000, st_r.irq_st};
			if (wb_we_i)
				st_nxt.irq_st = (st_r.irq_st & ~wval[1:0]) | evt;
		end
		else if (req && wb_adr_i == 12'(sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_IRQ_MSK))
		begin
			rdata = {30'h0000_0000, st_r.irq_msk};
			if (wb_we_i)
				st_nxt.irq_msk = (st_r.irq_msk & ~wmask[1:0]) | wval[1:0];
		end
		st_nxt.dat = (req && !wb_we_i) ? rdata : 32'h0000_0000;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.dat;
	assign tx_level_out = st_r.tx_o;
	assign signal_loss_level_out = st_r.los_o;
	assign scan_comparator_level_out = st_r.cmp_o;
	assign irq_o = |(st_r.irq_st & st_r.irq_msk);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_ack_next_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after request");

	a_stat_read: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && !wb_we_i && wb_adr_i == 12'hC20) |=> (wb_dat_o[31] && wb_dat_o[15:0] == 16'hFFFF
		&& wb_dat_o[30:26] == $past(sy_tx) && wb_dat_o[25:21] == $past(sy_los)))
		else $error("level status read data wrong");

	a_ec_stale: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && !wb_we_i && wb_adr_i == 12'h830) |=> (wb_dat_o[16:0] == $past(st_r.snap)
		&& wb_dat_o[31:17] == 15'h0000))
		else $error("error counter read not pipelined");

	a_ec_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		cnt_clr |=> (cnt_val == 15'h0000 && !cnt_scale) || (cnt_val == 15'h0001 && $past(err_hit)))
		else $error("second read did not clear counter");

	a_ovf_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		(cnt_ovf && !cnt_clr) |=> cnt_ovf [*1])
		else $error("overflow indication lost without clear");

	a_fi_read: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && !wb_we_i && wb_adr_i == 12'h834) |=> (wb_dat_o[13:0] == $past(sy_freq)
		&& wb_dat_o[31:14] == 18'h00000))
		else $error("frequency readout wrong");

	a_level_override_enable_apply: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_r.level_override_enable |=> tx_level_out == $past(st_r.level_override_enable_tx))
		else $error("override level not applied");

	a_lvl_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		!st_r.level_override_enable |=> (signal_loss_level_out == $past(sy_los)
		&& scan_comparator_level_out == $past(sy_cmp)))
		else $error("status level not applied");

	a_level_override_enable_write: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && wb_we_i && wb_sel_i == 4'hF && wb_adr_i == 12'hC28) |=>
		(st_r.level_override_enable_los == $past(wb_dat_i[25:21]) && st_r.level_override_enable_cmp == $past(wb_dat_i[20:16])))
		else $error("override fields not written");

	a_irq_set: assert property (@(posedge sys_clk) disable iff (!nrst)
		(err_hit && st_r.irq_msk[0] && !(req && wb_we_i && wb_adr_i == 12'hC44))
		|=> irq_o && st_r.irq_st[0])
		else $error("error event did not raise interrupt");

	a_ack_single: assert property (@(posedge sys_clk) disable iff (!nrst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_wr_no_data: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && wb_we_i) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000))
		else $error("write cycle returned data");

	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && !wb_we_i && wb_adr_i[11:8] == 4'h9) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000))
		else $error("unmapped read returned data");

	a_ec_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && !wb_we_i && wb_adr_i == 12'h830) |=> (st_r.snap == {$past(sy_pdither), $past(cnt_scale),
		$past(cnt_val)}))
		else $error("error counter snapshot wrong");

	a_ec_even_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && !wb_we_i && wb_adr_i == 12'h830 && st_r.rd_odd && !err_hit) |=>
		(cnt_val == 15'h0000 && !cnt_scale))
		else $error("second read left counter set");

	a_cnt_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		(err_hit && !cnt_clr && !cnt_scale && cnt_val != 15'h7FFF) |=> (!cnt_scale
		&& cnt_val == $past(cnt_val) + 15'h0001))
		else $error("unscaled count did not step by one");

	a_cnt_steady: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!err_hit && !cnt_clr) |=> ($stable(cnt_val) && $stable(cnt_scale)))
		else $error("count moved without an error");

	a_scale_enter: assert property (@(posedge sys_clk) disable iff (!nrst)
		(err_hit && !cnt_clr && !cnt_scale && cnt_val == 15'h7FFF) |=> (cnt_scale && cnt_val == 15'h0100))
		else $error("scaled reporting not entered");

	a_level_override_enable_rest: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_r.level_override_enable |=> (signal_loss_level_out == $past(st_r.level_override_enable_los)
		&& scan_comparator_level_out == $past(st_r.level_override_enable_cmp)))
		else $error("override levels not applied");

	a_tx_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		!st_r.level_override_enable |=> tx_level_out == $past(sy_tx))
		else $error("status transmit level not applied");

	a_irq_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		(req && wb_we_i && wb_adr_i == 12'hC40 && wb_sel_i[0] && wb_dat_i[0] && !err_hit) |=> !st_r.irq_st[0])
		else $error("status bit not cleared by write");

endmodule : sdlfs_regs

/* sdlfs_regs_tb_top.sv */
// Self-checking bench for the level, frequency and error-count register bank
`timescale 1ns/1ps
module sdlfs_regs_tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, err_hit, phase_dither_bit, freq_dither_bit, irq_o;
	logic [11:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, snap, q, ovr;
	logic [12:0] freq_offset_value;
	logic [4:0] tx_level_in, signal_loss_level_in, scan_comparator_level_in, tl, ll, cl;
	logic [4:0] tx_level_out, signal_loss_level_out, scan_comparator_level_out;
	int err_total, n_tests, cyc_cnt, raw, rd_par;
	localparam logic [11:0] EC = sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_EC;
	localparam logic [11:0] FI = sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_FI;
	localparam logic [11:0] ST = sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_STAT;
	localparam logic [11:0] OV = sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_LEVEL_OVERRIDE_ENABLE;
	localparam logic [11:0] IS = sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_IRQ_ST;
	localparam logic [11:0] IM = sdlfs_pkg::BASE_ADR + sdlfs_pkg::OFF_IRQ_MSK;
	sdlfs_regs dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.err_hit(err_hit), .phase_dither_bit(phase_dither_bit), .freq_offset_value(freq_offset_value),
		.freq_dither_bit(freq_dither_bit), .tx_level_in(tx_level_in), .signal_loss_level_in(signal_loss_level_in),
		.scan_comparator_level_in(scan_comparator_level_in), .tx_level_out(tx_level_out),
		.signal_loss_level_out(signal_loss_level_out), .scan_comparator_level_out(scan_comparator_level_out),
		.irq_o(irq_o));
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do
		begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
		begin
			err_total++;
			$display("Error at %0t: no bus acknowledge", $time);
		end
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb
	function automatic logic [31:0] ec_exp(int r, logic d);
		return {15'h0, d, (r >= 32768) ? 1'b1 : 1'b0, (r >= 32768) ? 15'(r >> 7) : 15'(r)};
	endfunction : ec_exp
	task ec_rd;
		wb(EC, 1'b0, 32'h0, q);
		chk(q, snap);
		snap = ec_exp(raw, phase_dither_bit);
		rd_par++;
		if (rd_par % 2 == 0)
			raw = 0;
	endtask : ec_rd
	task hits(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			err_hit <= 1'b1;
		end
		@(posedge sys_clk);
		err_hit <= 1'b0;
		raw += n;
	endtask : hits
	task lvl_chk(input logic [4:0] t, input logic [4:0] l, input logic [4:0] c);
		chk({17'h0, tx_level_out, signal_loss_level_out, scan_comparator_level_out}, {17'h0, t, l, c});
	endtask : lvl_chk
	always @(posedge sys_clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000)
		begin
			err_total++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		{err_total, n_tests, cyc_cnt, raw, rd_par, snap} = '0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, err_hit, freq_dither_bit} = '0;
		void'($urandom(95));
		phase_dither_bit = 1'($urandom);
		freq_offset_value = 13'h0;
		tx_level_in = 5'h10;
		signal_loss_level_in = 5'h12;
		scan_comparator_level_in = 5'h00;
		nrst = 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		lvl_chk(5'h10, 5'h12, 5'h00);
		wb(ST, 1'b0, 32'h0, q);
		chk(q, 32'hC240FFFF);
		wb(OV, 1'b0, 32'h0, q);
		chk(q, 32'h42100000);
		repeat (4)
		begin
			@(posedge sys_clk);
			{tl, ll, cl} = 15'($urandom);
			tx_level_in <= tl;
			signal_loss_level_in <= ll;
			scan_comparator_level_in <= cl;
			freq_offset_value <= 13'($urandom);
			freq_dither_bit <= 1'($urandom);
			repeat (4) @(posedge sys_clk);
			wb(ST, 1'b1, 32'h0, q);
			wb(ST, 1'b0, 32'h0, q);
			chk(q, {1'b1, tl, ll, cl, 16'hFFFF});
			lvl_chk(tl, ll, cl);
			wb(FI, 1'b0, 32'h0, q);
			wb(FI, 1'b0, 32'h0, q);
			chk(q, {18'h0, freq_offset_value, freq_dither_bit});
		end
		wb(OV, 1'b0, 32'h0, ovr);
		{tl, ll, cl} = 15'($urandom) | 15'h4000;
		wb(OV, 1'b1, {1'b1, tl, ll, cl, ovr[15:0]}, q);
		wb(OV, 1'b0, 32'h0, q);
		chk(q, {1'b1, tl, ll, cl, ovr[15:0]});
		repeat (2) @(posedge sys_clk);
		lvl_chk(tl, ll, cl);
		wb(OV, 1'b1, {1'b0, tl, ll, cl, ovr[15:0]}, q);
		repeat (2) @(posedge sys_clk);
		lvl_chk(tx_level_in, signal_loss_level_in, scan_comparator_level_in);
		hits(5);
		ec_rd();
		ec_rd();
		hits(1 + $urandom % 300);
		ec_rd();
		hits(7);
		ec_rd();
		ec_rd();
		hits(40000);
		ec_rd();
		ec_rd();
		ec_rd();
		wb(IM, 1'b1, 32'h1, q);
		wb(IS, 1'b1, 32'h3, q);
		@(posedge sys_clk);
		chk({31'h0, irq_o}, 32'h0);
		hits(1);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq_o}, 32'h1);
		wb(IS, 1'b0, 32'h0, q);
		chk(q & 32'h1, 32'h1);
		wb(IM, 1'b1, 32'h0, q);
		@(posedge sys_clk);
		chk({31'h0, irq_o}, 32'h0);
		wb(IM, 1'b1, 32'h1, q);
		wb(IS, 1'b1, 32'h1, q);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq_o}, 32'h0);
		wb(12'h900, 1'b1, 32'hFFFFFFFF, q);
		wb(12'h900, 1'b0, 32'h0, q);
		chk(q, 32'h0);
		wrap_up();
	end
endmodule : sdlfs_regs_tb_top

/* sdlfs_sync.sv */
// Two-stage synchroniser for a bundle of transceiver inputs
`timescale 1ns/1ps
module sdlfs_sync #(
	parameter int W = 30,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sdlfs_sync_s;

	sdlfs_sync_s st_r;
	sdlfs_sync_s st_nxt;

	if (W < 1) $error("sdlfs_sync width must be positive");

	always_comb
	begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			st_r <= {RST, RST};
		else
			st_r <= st_nxt;
	end

	assign q = st_r.s2;

endmodule : sdlfs_sync
